/* File: hdl/cfe_consts.svh */
// Purpose: Constants of the fault and reset entry unit.
// Assumes: 32-bit addresses, bit 31 is the most significant bit.
// Notes:   Definitions only.
`ifndef CFE_CONSTS_SVH
`define CFE_CONSTS_SVH
`define CFE_VEC_RESET      32'h0000_0000
`define CFE_VEC_BOOT       32'h8000_0000
`define CFE_VEC_BREAK      32'h0000_0010
`define CFE_VEC_UNDEF      32'h0000_0020
`define CFE_VEC_ADDR       32'h0000_0030
`define CFE_RTE_MASK       32'hffff_fffc
`define CFE_AL_BIT         1
`define CFE_FLAGS_RST      3'h0
`define CFE_SM_POS         2
`define CFE_IE_POS         1
`define CFE_C_POS          0
`define CFE_BUS_OKAY       1'b0
`define CFE_HTRANS_BIT     1
`define CFE_ADDR_FLAGS     8'h00
`define CFE_ADDR_BPC       8'h04
`define CFE_ADDR_STATUS    8'h08
`define CFE_ADDR_CTRL      8'h0c
`endif

/* File: hdl/cfe_entry.sv */
// Purpose: Fault, reset and system break entry for a 32-bit RISC core.
// Assumes: Pipeline presents one executing instruction per cycle with exec_valid.
// Notes:   Peripheral irq is only ranked here; its own entry is handled elsewhere.
`timescale 1ns/10ps
`include "cfe_consts.svh"

// Summary of operation
// RL1 - Reserved opcode faults and is cancelled
// RL2 - Undefined opcode fault beats peripheral irq
// RL3 - Fault saves flags, keeps stack_mode, clears others
// RL4 - backup_pc gets faulting instruction address
// RL5 - Return forces low two pc bits zero
// RL6 - Undefined opcode fault vectors to 0x20
// RL7 - Halfword access at odd address faults
// RL8 - Word, lock, unlock need aligned address; the code has no lock or unlock kind and checks word accesses only
// RL9 - Faulting access never reaches memory
// RL10 - Address fault beats peripheral irq
// RL11 - backup_pc gets address faulting instruction address
// RL12 - Address fault vectors to 0x30
// RL13 - Reset low traps always, highest rank
// RL14 - Reset clears live flags, saved undefined
// RL15 - Reset fetches 0 or boot ROM base
// RL16 - Break pin falling edge, ignores enable
// RL17 - No break after aligned 16-bit non-branch
// RL18 - Break saves flags then clears all
// RL19 - Break saves current word-aligned pc
// RL20 - Break vectors to 0x10
// RL21 - Vector then fetched as ordinary instruction
// RL22 - Return restores flags and pc
// RL23 - Break sampled only at word boundaries
module cfe_entry
  import cfe_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        boot_mode,
  input  wire logic        system_break_n,
  input  wire logic        exec_valid,
  input  wire logic [31:0] exec_pc,
  input  wire logic [31:0] next_pc,
  input  wire logic        exec_opcode_reserved,
  input  wire logic        exec_is_16bit,
  input  wire logic        exec_is_branch,
  input  wire logic        exec_return_from_fault,
  input  wire cfe_mem_t    exec_mem_kind,
  input  wire logic [31:0] exec_mem_addr,
  input  wire logic        exec_arith_flag_wr,
  input  wire logic        exec_arith_flag_val,
  input  wire logic        exec_int_enable_wr,
  input  wire logic        exec_int_enable_val,
  input  wire logic        peripheral_irq,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             mem_access_en,
  output logic             exec_commit,
  output logic             redirect_valid,
  output logic [31:0]      redirect_pc,
  output cfe_event_t       taken_event,
  output logic             stack_mode,
  output logic             interrupt_enable_flag,
  output logic             arith_flag,
  output logic [2:0]       saved_flags,
  output logic [31:0]      backup_pc,
  output logic             irq_accept
);

  logic        brk_s1_q;
  logic        brk_s2_q;
  logic        brk_s3_q;
  logic        brk_pend_q;
  logic        boot_q;
  logic        boot_done_q;
  logic        misaligned;
  logic        undef_hit;
  logic        addr_hit;
  logic        brk_window;
  logic        brk_hit;
  logic        irq_hit;
  logic        brk_arm_q;
  logic        irq_en_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  bus_addr_q;
  logic [31:0] pc_out_d;
  cfe_event_t  ev_d;

  // Pin passes two flops before the edge detector; the third stage is history.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_s1_q <= 1'b1;
      brk_s2_q <= 1'b1;
      brk_s3_q <= 1'b1;
    end else begin
      brk_s1_q <= system_break_n;
      brk_s2_q <= brk_s1_q;
      brk_s3_q <= brk_s2_q;
    end
  end

  // A falling edge is remembered until a word boundary lets it in.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_pend_q <= 1'b0;
    end else if (brk_s3_q && !brk_s2_q) begin
      brk_pend_q <= 1'b1; // [RL16]
    end else if (brk_hit) begin
      brk_pend_q <= 1'b0;
    end
  end

  // Boot strap is caught on the first clock after reset release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_q      <= 1'b0;
      boot_done_q <= 1'b0;
    end else if (!boot_done_q) begin
      boot_q      <= boot_mode;
      boot_done_q <= 1'b1;
    end
  end

  always_comb begin
    misaligned = 1'b0;
    case (exec_mem_kind)
      CFE_MEM_HALF: misaligned = exec_mem_addr[0]; // [RL7]
      CFE_MEM_WORD: misaligned = |exec_mem_addr[`CFE_AL_BIT:0]; // [RL8]
      default:      misaligned = 1'b0;
    endcase
  end

  // Break may enter only where the next instruction starts on a word boundary,
  // which excludes the gap after an aligned 16-bit non-branch.
  assign brk_window = exec_valid && !next_pc[1] &&
                      !(exec_is_16bit && !exec_pc[1] && !exec_is_branch); // [RL17] [RL23]
  assign undef_hit  = exec_valid && exec_opcode_reserved; // [RL1]
  assign addr_hit   = exec_valid && !exec_opcode_reserved && misaligned;
  assign brk_hit    = brk_pend_q && brk_window && !undef_hit && !addr_hit;
  assign irq_hit    = peripheral_irq && interrupt_enable_flag && brk_window &&
                      !undef_hit && !addr_hit && !brk_pend_q && irq_en_q; // [RL2] [RL10]

  always_comb begin
    ev_d     = CFE_EV_NONE;
    pc_out_d = 32'h0000_0000;
    if (undef_hit) begin
      ev_d     = CFE_EV_UNDEF;
      pc_out_d = `CFE_VEC_UNDEF; // [RL6]
    end else if (addr_hit) begin
      ev_d     = CFE_EV_ADDR;
      pc_out_d = `CFE_VEC_ADDR; // [RL12]
    end else if (brk_hit) begin
      ev_d     = CFE_EV_BREAK;
      pc_out_d = `CFE_VEC_BREAK; // [RL20]
    end else if (irq_hit) begin
      ev_d     = CFE_EV_IRQ;
    end else if (exec_valid && exec_return_from_fault) begin
      pc_out_d = backup_pc & `CFE_RTE_MASK; // [RL5] [RL22]
    end
  end

  // Reset wins over all else by its asynchronous clear, then boot vector.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      redirect_valid <= 1'b0;
      redirect_pc    <= `CFE_VEC_RESET;
      taken_event    <= CFE_EV_NONE;
      irq_accept     <= 1'b0;
      exec_commit    <= 1'b0;
      mem_access_en  <= 1'b0;
    end else if (!boot_done_q) begin
      redirect_valid <= 1'b1; // [RL13]
      redirect_pc    <= boot_mode ? `CFE_VEC_BOOT : `CFE_VEC_RESET; // [RL15]
      taken_event    <= CFE_EV_NONE;
      irq_accept     <= 1'b0;
      exec_commit    <= 1'b0;
      mem_access_en  <= 1'b0;
    end else begin
      // The vector is just a fetch target; the jump there runs as normal code.
      redirect_valid <= (ev_d inside {CFE_EV_UNDEF, CFE_EV_ADDR, CFE_EV_BREAK}) ||
                        (exec_valid && exec_return_from_fault && ev_d == CFE_EV_NONE); // [RL21]
      redirect_pc    <= pc_out_d;
      taken_event    <= ev_d;
      irq_accept     <= irq_hit;
      exec_commit    <= exec_valid && !undef_hit && !addr_hit; // [RL1]
      mem_access_en  <= exec_valid && exec_mem_kind != CFE_MEM_NONE &&
                        !undef_hit && !addr_hit; // [RL9]
    end
  end

  // Live flags only; the saved copies in the next block are left alone by reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_mode            <= 1'b0; // [RL14]
      interrupt_enable_flag <= 1'b0;
      arith_flag            <= 1'b0;
    end else if (undef_hit || addr_hit) begin
      interrupt_enable_flag <= 1'b0; // [RL3]
      arith_flag            <= 1'b0;
    end else if (brk_hit) begin
      stack_mode            <= 1'b0; // [RL18]
      interrupt_enable_flag <= 1'b0;
      arith_flag            <= 1'b0;
    end else if (exec_valid && exec_return_from_fault) begin
      stack_mode            <= saved_flags[`CFE_SM_POS]; // [RL22]
      interrupt_enable_flag <= saved_flags[`CFE_IE_POS];
      arith_flag            <= saved_flags[`CFE_C_POS];
    end else begin
      if (exec_valid && exec_int_enable_wr) begin
        interrupt_enable_flag <= exec_int_enable_val;
      end
      if (exec_valid && exec_arith_flag_wr) begin
        arith_flag <= exec_arith_flag_val;
      end
    end
  end

  // Saved state has no reset: its value after the reset trap is undefined.
  always_ff @(posedge hclk) begin
    if (undef_hit || addr_hit || brk_hit) begin
      saved_flags <= {stack_mode, interrupt_enable_flag, arith_flag}; // [RL3] [RL18]
    end
    if (undef_hit || addr_hit) begin
      backup_pc <= exec_pc; // [RL4] [RL11]
    end else if (brk_hit) begin
      backup_pc <= next_pc; // [RL19]
    end
  end

  // Bus slave: zero wait states, OKAY always, control register gates irq rank.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q  <= 1'b0;
      rd_pend_q  <= 1'b0;
      bus_addr_q <= 8'h00;
      irq_en_q   <= 1'b1;
      brk_arm_q  <= 1'b0;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= `CFE_BUS_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `CFE_BUS_OKAY;
      if (hready) begin
        wr_pend_q  <= hsel && htrans[`CFE_HTRANS_BIT] && hwrite;
        rd_pend_q  <= hsel && htrans[`CFE_HTRANS_BIT] && !hwrite;
        bus_addr_q <= haddr[7:0];
      end
      if (wr_pend_q && bus_addr_q == `CFE_ADDR_CTRL) begin
        irq_en_q <= hwdata[0];
      end
      brk_arm_q <= brk_pend_q;
      if (hready && hsel && htrans[`CFE_HTRANS_BIT] && !hwrite) begin
        case (haddr[7:0])
          `CFE_ADDR_FLAGS:  hrdata <= {24'h000000, 1'b0, saved_flags, 1'b0,
                                       stack_mode, interrupt_enable_flag, arith_flag};
          `CFE_ADDR_BPC:    hrdata <= backup_pc;
          `CFE_ADDR_STATUS: hrdata <= {27'h0000000, boot_q, brk_arm_q, taken_event};
          `CFE_ADDR_CTRL:   hrdata <= {31'h00000000, irq_en_q};
          default:          hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* File: hdl/cfe_pkg.sv */
// Purpose: Types of the fault and reset entry unit.
// Assumes: Used together with cfe_consts.svh.
// Notes:   Holds types only.
package cfe_pkg;
  typedef enum logic [2:0] {
    CFE_EV_NONE,
    CFE_EV_UNDEF,
    CFE_EV_ADDR,
    CFE_EV_BREAK,
    CFE_EV_IRQ
  } cfe_event_t;
  typedef enum logic [1:0] {
    CFE_MEM_NONE,
    CFE_MEM_HALF,
    CFE_MEM_WORD
  } cfe_mem_t;
endpackage

/* File: sim/cfe_entry_sva.sv */
// Purpose: Assertions on the fault and reset entry unit.
// Assumes: Top ports only, one clock.
// Notes:   The return check presumes no break is pending.
`timescale 1ns/10ps
`include "cfe_consts.svh"
module cfe_entry_sva
  import cfe_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        boot_mode,
  input wire logic        exec_valid,
  input wire logic [31:0] exec_pc,
  input wire logic        exec_opcode_reserved,
  input wire logic        exec_is_16bit,
  input wire logic        exec_is_branch,
  input wire logic        exec_return_from_fault,
  input wire cfe_mem_t    exec_mem_kind,
  input wire logic [31:0] exec_mem_addr,
  input wire logic        mem_access_en,
  input wire logic        exec_commit,
  input wire logic        redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire cfe_event_t  taken_event,
  input wire logic        stack_mode,
  input wire logic        interrupt_enable_flag,
  input wire logic        arith_flag,
  input wire logic [2:0]  saved_flags,
  input wire logic [31:0] backup_pc,
  input wire logic        irq_accept
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic [2:0] live = {stack_mode, interrupt_enable_flag, arith_flag};
  wire logic undef = exec_valid && exec_opcode_reserved;
  wire logic misal = exec_valid && !exec_opcode_reserved && (exec_mem_kind == CFE_MEM_HALF ?
    exec_mem_addr[0] : exec_mem_kind == CFE_MEM_WORD && exec_mem_addr[1:0] != 2'h0);
  a_undef_entry: assert property (undef |=> redirect_valid && !exec_commit
    && !irq_accept && redirect_pc == `CFE_VEC_UNDEF) else $error("undef entry");
  a_fault_flags: assert property (undef || misal |=> live == {$past(stack_mode), 2'h0}
    && saved_flags == $past(live)) else $error("fault flags");
  a_fault_bpc: assert property (undef || misal |=> backup_pc == $past(exec_pc))
    else $error("fault backup pc");
  a_misal_entry: assert property (misal |=> redirect_pc == `CFE_VEC_ADDR
    && !mem_access_en && !irq_accept && redirect_valid) else $error("address fault");
  a_return_pc: assert property (exec_valid && exec_return_from_fault && !undef && !misal
    |=> redirect_pc == ($past(backup_pc) & `CFE_RTE_MASK) && live == $past(saved_flags))
    else $error("return");
  a_reset_flags: assert property (disable iff (1'h0) !hresetn |-> live == `CFE_FLAGS_RST)
    else $error("reset flags");
  a_reset_vector: assert property (disable iff (1'h0) !hresetn ##1 hresetn |=> redirect_valid
    && redirect_pc == ($past(boot_mode) ? `CFE_VEC_BOOT : `CFE_VEC_RESET)) else $error("reset");
  a_break_entry: assert property (taken_event == CFE_EV_BREAK |-> redirect_valid
    && redirect_pc == `CFE_VEC_BREAK && live == 3'h0 && backup_pc[1:0] == 2'h0
    && saved_flags == $past(live)) else $error("break entry");
  a_no_break: assert property (exec_valid && exec_is_16bit && !exec_is_branch && !exec_pc[1]
    |=> taken_event != CFE_EV_BREAK) else $error("break after short op");
endmodule
bind cfe_entry cfe_entry_sva chk_u (.*);

/* File: sim/cfe_pipe_model.sv */
// Purpose: Pipeline and break pin model facing the entry unit.
// Assumes: One instruction per call, then idle cycles.
// Notes:   Idle cycles invert pc and address so stale values never look valid.
`timescale 1ns/10ps
module cfe_pipe_model
  import cfe_pkg::*;
(
  input  wire logic   hclk,
  output logic        exec_valid,
  output logic [31:0] exec_pc,
  output logic [31:0] next_pc,
  output logic        exec_opcode_reserved,
  output logic        exec_is_16bit,
  output logic        exec_is_branch,
  output logic        exec_return_from_fault,
  output cfe_mem_t    exec_mem_kind,
  output logic [31:0] exec_mem_addr,
  output logic        flag_wr,
  output logic        flag_val,
  output logic        peripheral_irq,
  output logic        system_break_n
);
  logic [6:0] f_q;
  assign {peripheral_irq, exec_opcode_reserved, exec_return_from_fault, exec_is_16bit,
    exec_is_branch, flag_wr, flag_val} = f_q;
  initial begin
    exec_valid = 1'h0;
    f_q = 7'h0;
    exec_mem_kind = CFE_MEM_NONE;
    exec_pc = 32'h0;
    next_pc = 32'h0;
    exec_mem_addr = 32'h0;
    system_break_n = 1'h1;
  end
  task automatic issue(input logic [31:0] pc, input logic [6:0] f, input cfe_mem_t k,
                       input logic [31:0] ad);
    @(posedge hclk);
    exec_valid <= 1'h1;
    exec_pc <= pc;
    next_pc <= pc + (f[3] ? 32'h2 : 32'h4);
    f_q <= f;
    exec_mem_kind <= k;
    exec_mem_addr <= ad;
    @(posedge hclk);
    exec_valid <= 1'h0;
    f_q <= 7'h0;
    exec_pc <= ~exec_pc;
    next_pc <= ~next_pc;
    exec_mem_addr <= ~exec_mem_addr;
    exec_mem_kind <= CFE_MEM_NONE;
    @(posedge hclk);
  endtask
  task automatic brk();
    @(posedge hclk);
    system_break_n <= 1'h0;
    repeat (3) @(posedge hclk);
    system_break_n <= 1'h1;
  endtask
endmodule

/* File: sim/cpu_fault_and_reset_entry_bench.sv */
// Purpose: Self-checking bench for the fault and reset entry unit.
// Assumes: The model spaces instructions with idle cycles.
// Notes:   Redirect targets are queued and checked as they appear.
`timescale 1ns/10ps
`include "cfe_consts.svh"
module cpu_fault_and_reset_entry_bench
  import cfe_pkg::*;
;
  logic hclk = 1'h0, hresetn = 1'h1, boot_mode = 1'h0, hsel = 1'h0, hwrite = 1'h0, f;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0, saved_flags;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, redirect_pc, backup_pc, rd, p, a;
  logic [31:0] exec_pc, next_pc, exec_mem_addr;
  logic hreadyout, hresp, mem_access_en, exec_commit, redirect_valid, stack_mode, arith_flag;
  logic interrupt_enable_flag, irq_accept, exec_valid, exec_opcode_reserved, exec_is_16bit;
  logic exec_is_branch, exec_return_from_fault, flag_wr, flag_val, peripheral_irq;
  logic system_break_n;
  cfe_mem_t exec_mem_kind;
  cfe_event_t taken_event;
  logic [31:0] exp_q[$];
  int err_count = 0, checks_done = 0;
  cfe_entry dut_u (.*, .hready(hreadyout), .exec_arith_flag_wr(flag_wr),
    .exec_int_enable_wr(flag_wr), .exec_arith_flag_val(flag_val), .exec_int_enable_val(flag_val));
  cfe_pipe_model pm_u (.*);
  always #5 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (exp_q.size() != 0) err_count++;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hwait();
    repeat (50) begin
      @(posedge hclk);
      if (hreadyout === 1'h1) return;
    end
    err_count++;
    wrap_up();
  endtask
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    hsize <= 3'h2;
    hwait();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rd = hrdata;
  endtask
  task automatic rst(input logic b);
    @(posedge hclk);
    hresetn <= 1'h0;
    boot_mode <= b;
    repeat (4) @(posedge hclk);
    exp_q.push_back(b ? `CFE_VEC_BOOT : `CFE_VEC_RESET);
    hresetn <= 1'h1;
    repeat (3) @(posedge hclk);
  endtask
  always @(posedge hclk)
    if (redirect_valid === 1'h1) chk(redirect_pc, exp_q.size() ? exp_q.pop_front() : 'x);
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hfdf0ffe9));
    for (int b = 1; b >= 0; b--) begin
      rst(b[0]);
      chk({stack_mode, interrupt_enable_flag, arith_flag}, 32'h0);
    end
    ahb(1'h0, `CFE_ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    ahb(1'h1, 32'h40, 32'h5);
    ahb(1'h0, 32'h40, 32'h0);
    chk(rd, 32'h0);
    pm_u.issue(32'h100, 7'h03, CFE_MEM_NONE, 32'h0);
    p = $urandom & 32'h0fff_fffe;
    exp_q.push_back(`CFE_VEC_UNDEF);
    pm_u.issue(p, 7'h60, CFE_MEM_NONE, 32'h0);
    chk(backup_pc, p);
    chk({exec_commit, irq_accept, stack_mode, interrupt_enable_flag, arith_flag, saved_flags}, 32'h3);
    ahb(1'h0, `CFE_ADDR_FLAGS, 32'h0);
    chk(rd, 32'h30);
    exp_q.push_back(p & `CFE_RTE_MASK);
    pm_u.issue(32'h24, 7'h10, CFE_MEM_NONE, 32'h0);
    chk({stack_mode, interrupt_enable_flag, arith_flag}, 32'h3);
    for (int i = 0; i < 8; i++) begin
      f = i[2] ? (i[1:0] != 2'h0) : i[0];
      a = ($urandom & 32'hffff_fffc) | i[1:0];
      pm_u.issue(32'h1fc, 7'h03, CFE_MEM_NONE, 32'h0);
      if (f) exp_q.push_back(`CFE_VEC_ADDR);
      pm_u.issue(32'h200 + i * 2, {f, 6'h0}, i[2] ? CFE_MEM_WORD : CFE_MEM_HALF, a);
      chk({mem_access_en, f & irq_accept}, {!f, 1'h0});
      if (f) chk(backup_pc, 32'h200 + i * 2);
    end
    pm_u.issue(32'h2fc, 7'h03, CFE_MEM_NONE, 32'h0);
    pm_u.brk();
    repeat (4) @(posedge hclk);
    pm_u.issue(32'h300, 7'h08, CFE_MEM_NONE, 32'h0);
    chk(taken_event, CFE_EV_NONE);
    exp_q.push_back(`CFE_VEC_BREAK);
    pm_u.issue(32'h302, 7'h08, CFE_MEM_NONE, 32'h0);
    chk(backup_pc, 32'h304);
    chk({stack_mode, interrupt_enable_flag, arith_flag, saved_flags}, 32'h3);
    pm_u.issue(32'h3fc, 7'h03, CFE_MEM_NONE, 32'h0);
    pm_u.issue(32'h400, 7'h40, CFE_MEM_NONE, 32'h0);
    chk({irq_accept, taken_event}, {1'h1, CFE_EV_IRQ});
    ahb(1'h1, `CFE_ADDR_CTRL, 32'h0);
    ahb(1'h0, `CFE_ADDR_CTRL, 32'h0);
    chk({hresp, rd}, 33'h0);
    pm_u.issue(32'h404, 7'h40, CFE_MEM_NONE, 32'h0);
    chk(irq_accept, 32'h0);
    repeat (3) @(posedge hclk);
    wrap_up();
  end
endmodule
